//--- eec_pkg.sv
// Package of offsets, fields, modes and thresholds for the error event counters.
package eec_pkg;
   // Register byte offsets on the APB side.
   localparam logic [7:0] OFF_FRAMING_CHECK = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_THR_A = 8'h08;
   localparam logic [7:0] OFF_THR_B = 8'h0c;
   localparam logic [7:0] OFF_THR_C = 8'h10;
   localparam logic [7:0] OFF_ES_EN_FIRST = 8'h14;
   localparam logic [7:0] OFF_ES_EN_LAST = 8'h24;
   localparam logic [7:0] OFF_STATUS_FIRST = 8'h40;
   localparam logic [7:0] OFF_STATUS_LAST = 8'h7c;
   // Field positions.
   localparam int FCHK_BIT = 2;
   localparam int MODE_CODE_LSB = 0;
   localparam int MODE_FRAME_LSB = 2;
   localparam int MODE_CRC_BIT = 5;
   localparam int MODE_SIDE_LSB = 6;
   localparam int THR_C_USE_BIT = 0;
   localparam int FLAG_EXCESS_BIT = 0;
   localparam int FLAG_UNAVAIL_BIT = 1;
   // Reset values.
   localparam logic [7:0] RST_FRAMING_CHECK = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [15:0] RST_THR_A = 16'h0001;
   localparam logic [15:0] RST_THR_B = 16'h0008;
   localparam logic [7:0] RST_THR_C = 8'h00;
   localparam logic [7:0] RST_ES_EN = 8'h00;
   // Line codes.
   typedef enum logic [1:0] {
      EEC_AMI = 2'b00,
      EEC_B8ZS = 2'b01,
      EEC_HDB3 = 2'b10
   } eec_code_e;
   // Framing modes.
   typedef enum logic [2:0] {
      EEC_D4 = 3'b000,
      EEC_SLC96 = 3'b001,
      EEC_DDS = 3'b010,
      EEC_ESF = 3'b011,
      EEC_E1 = 3'b100
   } eec_frame_e;
   // E1 CRC-4 termination sides.
   typedef enum logic [1:0] {
      EEC_ET1 = 2'b00,
      EEC_ET1_REMOTE = 2'b01,
      EEC_NT1 = 2'b10,
      EEC_NT1_REMOTE = 2'b11
   } eec_side_e;
   // Zero run limits per line code.
   localparam logic [4:0] ZRUN_AMI = 5'h10;
   localparam logic [4:0] ZRUN_B8ZS = 5'h08;
   localparam logic [4:0] ZRUN_HDB3 = 5'h04;
   // Per-second thresholds.
   localparam logic [15:0] SES_T1_FRAMING = 16'h0008;
   localparam logic [15:0] SES_CRC6 = 16'h0140;
   localparam logic [15:0] SES_E1_FRAMING = 16'h0010;
   localparam logic [15:0] SES_CRC4 = 16'h0393;
   localparam logic [15:0] EXCESS_CRC6 = 16'h0140;
   localparam logic [15:0] EXCESS_CRC4 = 16'h0393;
   localparam logic [15:0] BURST_LOW = 16'h0001;
   localparam logic [3:0] UNAVAIL_RUN = 4'ha;
   // Event source bit positions in the errored-second enables.
   localparam int SRC_BPV = 0;
   localparam int SRC_FER = 1;
   localparam int SRC_CRC = 2;
   localparam int SRC_EBIT = 3;
   localparam int SRC_SA6A = 4;
   localparam int SRC_SA6B = 5;
   localparam int NUM_SRC = 6;
   // Status bank indices and E-bit multiframe frame numbers.
   localparam int NUM_CNT = 8;
   localparam int IDX_FLAGS = 8;
   localparam logic [3:0] E1_EBIT_FRAME_A = 4'hd;
   localparam logic [3:0] E1_EBIT_FRAME_B = 4'hf;
endpackage

//--- eec_cnt.sv
// Saturating event counter with a clear that yields to a same-cycle event.
`timescale 1ns/1ps
`default_nettype none
module eec_cnt #(
   parameter int WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic inc,
   input wire logic clr,
   output logic [WIDTH-1:0] value
);
   logic [WIDTH-1:0] count_reg;

   // Saturate at all ones so a long outage never wraps back to small counts.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= '0;
      end else if (clr) begin
         count_reg <= inc ? WIDTH'(1) : '0;
      end else if (inc && !(&count_reg)) begin
         count_reg <= count_reg + WIDTH'(1);
      end
   end

   assign value = count_reg;
endmodule
`default_nettype wire

//--- eec_zero_run.sv
// Detector for a run of received zeros reaching a programmable length.
`timescale 1ns/1ps
`default_nettype none
module eec_zero_run #(
   parameter int WIDTH = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic bit_strobe,
   input wire logic pulse,
   input wire logic [WIDTH-1:0] limit,
   output logic hit
);
   logic [WIDTH-1:0] run_reg;

   // The run counter parks at the limit, so one long run gives one event.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_reg <= '0;
      end else if (bit_strobe) begin
         if (pulse) begin
            run_reg <= '0;
         end else if (run_reg != limit) begin
            run_reg <= run_reg + WIDTH'(1);
         end
      end
   end

   // Fires on the zero that brings the run up to the limit.
   assign hit = bit_strobe && !pulse && (run_reg == limit - WIDTH'(1));
endmodule
`default_nettype wire

//--- eec_top.sv
// Receive error event counters and second classification for one channel.
`timescale 1ns/1ps
`default_nettype none
module eec_top #(
   parameter int CNT_WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bit_strobe,
   input wire logic pulse_pos,
   input wire logic pulse_neg,
   input wire logic subst_viol,
   input wire logic code_viol,
   input wire logic terminal_framing_bit_err,
   input wire logic signaling_framing_bit_err,
   input wire logic slot24_align_err,
   input wire logic extended_superframe_framing_bit_err,
   input wire logic frame_alignment_word_err,
   input wire logic non_alignment_bit2_err,
   input wire logic crc_err,
   input wire logic ebit_valid,
   input wire logic ebit_value,
   input wire logic [3:0] mf_frame,
   input wire logic sa6_valid,
   input wire logic [3:0] sa6_code,
   input wire logic second_ref,
   output logic unavailable_alarm,
   output logic excess_crc_alarm
);
   // Software-visible control registers.
   logic [7:0] framing_check_control;
   logic [7:0] mode_reg;
   logic [15:0] second_threshold_reg_a;
   logic [15:0] second_threshold_reg_b;
   logic [7:0] second_threshold_reg_c;
   logic [7:0] es_enable_reg [5];
   // Decoded configuration.
   eec_pkg::eec_code_e line_code;
   eec_pkg::eec_frame_e frame_mode;
   eec_pkg::eec_side_e e1_side;
   logic fchk;
   logic crc_mode;
   logic e1_crc;
   // Event strobes of this cycle.
   logic mark;
   logic last_pol_reg;
   logic pol_viol;
   logic zrun_hit;
   logic [4:0] zrun_limit;
   logic [eec_pkg::NUM_SRC-1:0] ev;
   // Per-second state.
   logic sec_sync1_reg;
   logic sec_sync2_reg;
   logic sec_last_reg;
   logic sec_tick;
   logic [15:0] tally_reg;
   logic [15:0] tally_now;
   logic [15:0] crc_sec_reg;
   logic [15:0] crc_sec_now;
   logic [eec_pkg::NUM_SRC-1:0] seen_reg;
   logic [eec_pkg::NUM_SRC-1:0] seen_now;
   logic [eec_pkg::NUM_SRC-1:0] es_enables;
   logic src_event;
   logic [15:0] ses_hard;
   logic [15:0] ses_thr;
   logic [15:0] excess_thr;
   logic is_es;
   logic is_ses;
   logic is_bes;
   logic excess_live;
   logic excess_last_reg;
   logic unavail_reg;
   logic [3:0] run_reg;
   logic enter_unavail;
   logic leave_unavail;
   logic inhibit;
   // Counter bank.
   logic [eec_pkg::NUM_CNT-1:0] cnt_inc;
   logic [eec_pkg::NUM_CNT-1:0] cnt_clr;
   logic [CNT_WIDTH-1:0] cnt_val [eec_pkg::NUM_CNT];
   // Bus decode.
   logic wr_en;
   logic rd_setup;
   logic addr_mapped;
   logic [3:0] stat_idx;
   logic [31:0] rd_value;

   // Configuration fields.
   assign line_code = eec_pkg::eec_code_e'(
      mode_reg[eec_pkg::MODE_CODE_LSB +: 2]);
   assign frame_mode = eec_pkg::eec_frame_e'(
      mode_reg[eec_pkg::MODE_FRAME_LSB +: 3]);
   assign e1_side = eec_pkg::eec_side_e'(
      mode_reg[eec_pkg::MODE_SIDE_LSB +: 2]);
   assign fchk = framing_check_control[eec_pkg::FCHK_BIT];
   assign e1_crc = (frame_mode == eec_pkg::EEC_E1) &&
                   mode_reg[eec_pkg::MODE_CRC_BIT];
   assign crc_mode = (frame_mode == eec_pkg::EEC_ESF) || e1_crc;

   // Zero run limit follows the line code; reserved codes take the AMI limit.
   always_comb begin
      case (line_code)
         eec_pkg::EEC_B8ZS: zrun_limit = eec_pkg::ZRUN_B8ZS;
         eec_pkg::EEC_HDB3: zrun_limit = eec_pkg::ZRUN_HDB3;
         default: zrun_limit = eec_pkg::ZRUN_AMI;
      endcase
   end

   assign mark = pulse_pos || pulse_neg;

   eec_zero_run #(
      .WIDTH(5)
   ) u_zero_run (
      .pclk(pclk),
      .presetn(presetn),
      .bit_strobe(bit_strobe),
      .pulse(mark),
      .limit(zrun_limit),
      .hit(zrun_hit)
   );

   // Remember the polarity of the last mark to spot alternation breaks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_pol_reg <= 1'b0;
      end else if (bit_strobe && mark) begin
         last_pol_reg <= pulse_pos;
      end
   end

   // Two marks of one polarity are a violation unless they belong to a
   // valid zero substitution, which the framer flags for us.
   assign pol_viol = bit_strobe && mark && (pulse_pos == last_pol_reg) &&
                     !(subst_viol && line_code != eec_pkg::EEC_AMI);

   // Classify this cycle's events by line code and framing mode.
   always_comb begin
      ev = '0;
      ev[eec_pkg::SRC_BPV] = pol_viol || zrun_hit;
      if (line_code != eec_pkg::EEC_AMI) begin
         ev[eec_pkg::SRC_BPV] = pol_viol || zrun_hit || code_viol;
      end
      case (frame_mode)
         eec_pkg::EEC_D4, eec_pkg::EEC_SLC96: begin
            ev[eec_pkg::SRC_FER] = terminal_framing_bit_err ||
               (fchk && signaling_framing_bit_err);
         end
         eec_pkg::EEC_DDS: begin
            ev[eec_pkg::SRC_FER] = terminal_framing_bit_err ||
               signaling_framing_bit_err || slot24_align_err;
         end
         eec_pkg::EEC_ESF: begin
            ev[eec_pkg::SRC_FER] = extended_superframe_framing_bit_err;
         end
         eec_pkg::EEC_E1: begin
            ev[eec_pkg::SRC_FER] = frame_alignment_word_err ||
               (!fchk && non_alignment_bit2_err);
         end
         default: begin
            ev[eec_pkg::SRC_FER] = 1'b0;
         end
      endcase
      ev[eec_pkg::SRC_CRC] = crc_mode && crc_err;
      ev[eec_pkg::SRC_EBIT] = e1_crc && ebit_valid && !ebit_value &&
         (mf_frame == eec_pkg::E1_EBIT_FRAME_A ||
          mf_frame == eec_pkg::E1_EBIT_FRAME_B);
      ev[eec_pkg::SRC_SA6A] = e1_crc && sa6_valid &&
         (sa6_code[3:1] == 3'h1);
      ev[eec_pkg::SRC_SA6B] = e1_crc && sa6_valid &&
         (sa6_code[3:2] == 2'h0) && sa6_code[0];
   end

   // Default trigger and hardwired severe threshold for each mode.
   always_comb begin
      src_event = ev[eec_pkg::SRC_FER];
      ses_hard = eec_pkg::SES_T1_FRAMING;
      if (frame_mode == eec_pkg::EEC_ESF) begin
         src_event = ev[eec_pkg::SRC_CRC];
         ses_hard = eec_pkg::SES_CRC6;
      end else if (frame_mode == eec_pkg::EEC_E1 && !e1_crc) begin
         ses_hard = eec_pkg::SES_E1_FRAMING;
      end else if (e1_crc) begin
         ses_hard = eec_pkg::SES_CRC4;
         case (e1_side)
            eec_pkg::EEC_ET1: src_event = ev[eec_pkg::SRC_CRC];
            eec_pkg::EEC_ET1_REMOTE: src_event = ev[eec_pkg::SRC_EBIT];
            eec_pkg::EEC_NT1: src_event = ev[eec_pkg::SRC_SA6A];
            eec_pkg::EEC_NT1_REMOTE: src_event = ev[eec_pkg::SRC_SA6B];
            default: src_event = ev[eec_pkg::SRC_CRC];
         endcase
      end
   end

   // Programmed thresholds override the hardwired ones when selected.
   assign ses_thr = second_threshold_reg_c[eec_pkg::THR_C_USE_BIT] ?
                    second_threshold_reg_b : ses_hard;
   assign excess_thr = (frame_mode == eec_pkg::EEC_ESF) ?
                       eec_pkg::EXCESS_CRC6 : eec_pkg::EXCESS_CRC4;

   // Second reference comes from a pin: two flops, then an edge detect.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_sync1_reg <= 1'b0;
         sec_sync2_reg <= 1'b0;
         sec_last_reg <= 1'b0;
      end else begin
         sec_sync1_reg <= second_ref;
         sec_sync2_reg <= sec_sync1_reg;
         sec_last_reg <= sec_sync2_reg;
      end
   end

   assign sec_tick = sec_sync2_reg && !sec_last_reg;

   // Tallies include this cycle's event so the closing cycle is not lost.
   assign tally_now = tally_reg + ((src_event && !(&tally_reg)) ?
                      16'h0001 : 16'h0000);
   assign crc_sec_now = crc_sec_reg + ((ev[eec_pkg::SRC_CRC] &&
                        !(&crc_sec_reg)) ? 16'h0001 : 16'h0000);
   assign seen_now = seen_reg | ev;

   // Per-second tallies are evaluated and cleared on the strobe.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tally_reg <= '0;
         crc_sec_reg <= '0;
         seen_reg <= '0;
      end else if (sec_tick) begin
         tally_reg <= '0;
         crc_sec_reg <= '0;
         seen_reg <= '0;
      end else begin
         tally_reg <= tally_now;
         crc_sec_reg <= crc_sec_now;
         seen_reg <= seen_now;
      end
   end

   // Any of the low six bits set in the five enable registers switches to enable mode.
   always_comb begin
      es_enables = '0;
      for (int i = 0; i < 5; i++) begin
         es_enables = es_enables | es_enable_reg[i][eec_pkg::NUM_SRC-1:0];
      end
   end

   // Errored second: enabled conditions, else the mode default or the
   // programmed errored threshold on the default source.
   always_comb begin
      if (es_enables != '0) begin
         is_es = |(seen_now & es_enables);
      end else if (second_threshold_reg_c[eec_pkg::THR_C_USE_BIT]) begin
         is_es = tally_now >= second_threshold_reg_a;
      end else begin
         is_es = tally_now != 16'h0000;
      end
   end

   assign is_ses = tally_now >= ses_thr;
   assign is_bes = (tally_now > eec_pkg::BURST_LOW) &&
                   (tally_now < ses_thr);

   // Excessive checksum alarm: live during the second, held for one more.
   assign excess_live = crc_mode && (crc_sec_reg >= excess_thr);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         excess_last_reg <= 1'b0;
      end else if (sec_tick) begin
         excess_last_reg <= crc_mode && (crc_sec_now >= excess_thr);
      end
   end

   // Run of like seconds: severe while available, non-severe while unavailable.
   assign enter_unavail = !unavail_reg && is_ses &&
                          (run_reg == eec_pkg::UNAVAIL_RUN - 4'h1);
   assign leave_unavail = unavail_reg && !is_ses &&
                          (run_reg == eec_pkg::UNAVAIL_RUN - 4'h1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unavail_reg <= 1'b0;
         run_reg <= '0;
      end else if (sec_tick) begin
         if (enter_unavail || leave_unavail) begin
            unavail_reg <= !unavail_reg;
            run_reg <= '0;
         end else if (is_ses != unavail_reg) begin
            run_reg <= run_reg + 4'h1;
         end else begin
            run_reg <= '0;
         end
      end
   end

   // The second that completes the entry run already counts as unavailable.
   assign inhibit = unavail_reg || enter_unavail;

   // Counter increments: raw events, then second classes on the strobe.
   assign cnt_inc[0] = ev[eec_pkg::SRC_BPV];
   assign cnt_inc[1] = ev[eec_pkg::SRC_FER];
   assign cnt_inc[2] = ev[eec_pkg::SRC_CRC];
   assign cnt_inc[3] = ev[eec_pkg::SRC_EBIT];
   assign cnt_inc[4] = sec_tick && is_es && !inhibit;
   assign cnt_inc[5] = sec_tick && is_bes && !inhibit;
   assign cnt_inc[6] = sec_tick && is_ses && !inhibit;
   assign cnt_inc[7] = sec_tick &&
                       ((unavail_reg && !leave_unavail) || enter_unavail);

   genvar g;
   generate
      for (g = 0; g < eec_pkg::NUM_CNT; g++) begin : g_cnt
         eec_cnt #(
            .WIDTH(CNT_WIDTH)
         ) u_cnt (
            .pclk(pclk),
            .presetn(presetn),
            .inc(cnt_inc[g]),
            .clr(cnt_clr[g]),
            .value(cnt_val[g])
         );
         // Writing a status register clears its counter.
         assign cnt_clr[g] = wr_en && paddr[7:6] == 2'h1 &&
                             stat_idx == 4'(g);
      end
   endgenerate

   // APB decode; every access completes with no wait states.
   assign wr_en = psel && penable && pwrite && addr_mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign stat_idx = paddr[5:2];
   assign addr_mapped = (paddr[1:0] == 2'h0) &&
      (paddr <= eec_pkg::OFF_ES_EN_LAST ||
       (paddr >= eec_pkg::OFF_STATUS_FIRST &&
        paddr <= eec_pkg::OFF_STATUS_LAST));
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_mapped;

   // Control register writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         framing_check_control <= eec_pkg::RST_FRAMING_CHECK;
         mode_reg <= eec_pkg::RST_MODE;
         second_threshold_reg_a <= eec_pkg::RST_THR_A;
         second_threshold_reg_b <= eec_pkg::RST_THR_B;
         second_threshold_reg_c <= eec_pkg::RST_THR_C;
         for (int i = 0; i < 5; i++) begin
            es_enable_reg[i] <= eec_pkg::RST_ES_EN;
         end
      end else if (wr_en) begin
         case (paddr)
            eec_pkg::OFF_FRAMING_CHECK: framing_check_control <= pwdata[7:0];
            eec_pkg::OFF_MODE: mode_reg <= pwdata[7:0];
            eec_pkg::OFF_THR_A: second_threshold_reg_a <= pwdata[15:0];
            eec_pkg::OFF_THR_B: second_threshold_reg_b <= pwdata[15:0];
            eec_pkg::OFF_THR_C: second_threshold_reg_c <= pwdata[7:0];
            8'h14: es_enable_reg[0] <= pwdata[7:0];
            8'h18: es_enable_reg[1] <= pwdata[7:0];
            8'h1c: es_enable_reg[2] <= pwdata[7:0];
            8'h20: es_enable_reg[3] <= pwdata[7:0];
            eec_pkg::OFF_ES_EN_LAST: es_enable_reg[4] <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Read mux over control registers, the eight counters and the flags word.
   always_comb begin
      rd_value = 32'h0000_0000;
      if (paddr[7:6] == 2'h1) begin
         if (stat_idx < 4'(eec_pkg::NUM_CNT)) begin
            rd_value[CNT_WIDTH-1:0] = cnt_val[stat_idx[2:0]];
         end else if (stat_idx == 4'(eec_pkg::IDX_FLAGS)) begin
            rd_value[eec_pkg::FLAG_EXCESS_BIT] = excess_crc_alarm;
            rd_value[eec_pkg::FLAG_UNAVAIL_BIT] = unavail_reg;
         end
      end else begin
         case (paddr)
            eec_pkg::OFF_FRAMING_CHECK: rd_value[7:0] = framing_check_control;
            eec_pkg::OFF_MODE: rd_value[7:0] = mode_reg;
            eec_pkg::OFF_THR_A: rd_value[15:0] = second_threshold_reg_a;
            eec_pkg::OFF_THR_B: rd_value[15:0] = second_threshold_reg_b;
            eec_pkg::OFF_THR_C: rd_value[7:0] = second_threshold_reg_c;
            8'h14: rd_value[7:0] = es_enable_reg[0];
            8'h18: rd_value[7:0] = es_enable_reg[1];
            8'h1c: rd_value[7:0] = es_enable_reg[2];
            8'h20: rd_value[7:0] = es_enable_reg[3];
            eec_pkg::OFF_ES_EN_LAST: rd_value[7:0] = es_enable_reg[4];
            default: rd_value = 32'h0000_0000;
         endcase
      end
   end

   // Read data is captured in the setup cycle so it leaves a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_value;
      end
   end

   assign unavailable_alarm = unavail_reg;
   assign excess_crc_alarm = excess_live || excess_last_reg;
endmodule
`default_nettype wire

//--- eec_top_asserts.sv
// Checker on the bus and alarm outputs of the error counter block.
`timescale 1ns/1ps
`default_nettype none
module eec_top_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic crc_err,
   input wire logic second_ref,
   input wire logic unavailable_alarm,
   input wire logic excess_crc_alarm
);
   // One domain, so clock and reset are declared once.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Alarms, except a rising excess alarm, move only a few edges after the second mark is sampled.
   sequence s_acc; psel && penable; endsequence
   sequence s_sec;
      $past(second_ref, 2) || $past(second_ref, 3) || $past(second_ref, 4);
   endsequence
   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("ready low");
   property p_err_phase; pslverr |-> psel && penable; endproperty
   a_err_phase: assert property (p_err_phase) else $error("stray err");
   property p_misalign; s_acc ##0 (paddr[1:0] != 2'b00) |-> pslverr; endproperty
   a_misalign: assert property (p_misalign) else $error("no err");
   property p_mapped; s_acc ##0 (paddr == 8'h04) |-> !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("mode refused");
   property p_unav_up; $rose(unavailable_alarm) |-> s_sec; endproperty
   a_unav_up: assert property (p_unav_up) else $error("early enter");
   property p_unav_dn; $fell(unavailable_alarm) |-> s_sec; endproperty
   a_unav_dn: assert property (p_unav_dn) else $error("early leave");
   property p_exc_up;
      $rose(excess_crc_alarm) |-> $past(crc_err) || $past(crc_err, 2);
   endproperty
   a_exc_up: assert property (p_exc_up) else $error("excess no cause");
   property p_exc_dn; $fell(excess_crc_alarm) |-> s_sec; endproperty
   a_exc_dn: assert property (p_exc_dn) else $error("excess dropped");
endmodule
bind eec_top eec_top_asserts i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .crc_err(crc_err), .second_ref(second_ref),
   .unavailable_alarm(unavailable_alarm),
   .excess_crc_alarm(excess_crc_alarm));
`default_nettype wire

//--- eec_framer_model.sv
// Behavioural receive framer: line bits, error pulses and second mark.
`timescale 1ns/1ps
`default_nettype none
module eec_framer_model (
   input wire logic pclk,
   output logic bit_strobe,
   output logic pulse_pos,
   output logic pulse_neg,
   output logic [7:0] err_vec,
   output logic second_ref
);
   // All lines rest low; the bench calls the tasks hierarchically.
   initial {bit_strobe, pulse_pos, pulse_neg, err_vec, second_ref} = '0;
   // Dual-rail bits: n bits carrying marks p and q, then idle.
   task automatic bits(input int n, input bit p, input bit q);
      @(posedge pclk);
      {bit_strobe, pulse_pos, pulse_neg} <= {1'b1, p, q};
      repeat (n) @(posedge pclk);
      {bit_strobe, pulse_pos, pulse_neg} <= 3'b000;
   endtask
   // Hold error source i high for n edges, one event per edge.
   task automatic err(input int i, input int n);
      @(posedge pclk);
      err_vec[i] <= 1'b1;
      repeat (n) @(posedge pclk);
      err_vec[i] <= 1'b0;
   endtask
   // Second mark high three edges and low four, so the strobe has landed.
   task automatic sec();
      @(posedge pclk);
      second_ref <= 1'b1;
      repeat (3) @(posedge pclk);
      second_ref <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

//--- test_e1_t1_error_event_counters.sv
// Self-checking bench for the receive error event counters.
`timescale 1ns/1ps
`default_nettype none
module test_e1_t1_error_event_counters;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, ev;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, q;
   logic pready, pslverr, e, bit_strobe, pulse_pos, pulse_neg, second_ref;
   logic unavailable_alarm, excess_crc_alarm;
   int num_errors = 0, tests_run = 0, cycles = 0;
   int lim[3] = '{16, 8, 4}, nerr[3] = '{1, 3, 8};
   always #12.5 pclk = ~pclk;
   eec_framer_model i_fr (.pclk(pclk), .bit_strobe(bit_strobe),
      .pulse_pos(pulse_pos), .pulse_neg(pulse_neg), .err_vec(ev),
      .second_ref(second_ref));
   // Sa6 and substitution inputs rest idle; E bits sample frame 13.
   eec_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bit_strobe(bit_strobe), .pulse_pos(pulse_pos), .pulse_neg(pulse_neg),
      .subst_viol(1'b0), .code_viol(ev[5]), .terminal_framing_bit_err(ev[0]),
      .signaling_framing_bit_err(ev[1]), .slot24_align_err(ev[2]),
      .extended_superframe_framing_bit_err(ev[3]),
      .frame_alignment_word_err(ev[4]), .non_alignment_bit2_err(ev[5]),
      .crc_err(ev[6]), .ebit_valid(ev[7]), .ebit_value(1'b0),
      .mf_frame(eec_pkg::E1_EBIT_FRAME_A), .sa6_valid(1'b0),
      .sa6_code(4'h0), .second_ref(second_ref),
      .unavailable_alarm(unavailable_alarm),
      .excess_crc_alarm(excess_crc_alarm));
   // Cycle ceiling, far above what the sequence needs, cuts a hang short.
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         summarize();
      end
   end
   // One APB transfer; the request holds until ready is seen high.
   task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Compare and report a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] st(input int i);
      return eec_pkg::OFF_STATUS_FIRST + 8'(4 * i);
   endfunction
   // Read status counter i and compare it.
   task automatic rd(input int i, input logic [31:0] exp);
      apb(1'b0, st(i), 32'h0);
      chk(q, exp);
   endtask
   // Print the counts and the verdict, then stop.
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Main sequence; each group except the frame and crc test leaves the mode the next needs.
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, eec_pkg::OFF_THR_B, 32'h0);
      chk(q, 32'h8);
      apb(1'b0, 8'h31, 32'h0);
      chk(32'(e), 32'h1);
      $display("reset test done");
      i_fr.bits(1, 1'b1, 1'b0);
      i_fr.bits(1, 1'b0, 1'b1);
      // A run one short of the limit passes; a full run counts once.
      foreach (lim[c]) begin
         apb(1'b1, eec_pkg::OFF_MODE, c == 2 ? 32'h12 : 32'(c));
         apb(1'b1, st(0), 32'h0);
         i_fr.bits(lim[c] - 1, 1'b0, 1'b0);
         i_fr.bits(1, 1'b1, 1'b0);
         i_fr.bits(lim[c], 1'b0, 1'b0);
         i_fr.bits(1, 1'b0, 1'b1);
         rd(0, 32'h1);
      end
      apb(1'b1, eec_pkg::OFF_MODE, 32'h0);
      apb(1'b1, st(0), 32'h0);
      i_fr.bits(2, 1'b1, 1'b0);
      rd(0, 32'h1);
      $display("violation test done");
      apb(1'b1, st(1), 32'h0);
      i_fr.err(1, 1);
      i_fr.err(0, 1);
      rd(1, 32'h1);
      apb(1'b1, eec_pkg::OFF_FRAMING_CHECK, 32'h4);
      i_fr.err(1, 1);
      rd(1, 32'h2);
      apb(1'b1, eec_pkg::OFF_FRAMING_CHECK, 32'h0);
      apb(1'b1, st(2), 32'h0);
      i_fr.err(6, 1);
      rd(2, 32'h0);
      apb(1'b1, eec_pkg::OFF_MODE, 32'h0c);
      i_fr.err(3, 1);
      rd(1, 32'h3);
      i_fr.err(6, 319);
      @(negedge pclk);
      chk(32'(excess_crc_alarm), 32'h0);
      i_fr.err(6, 1);
      repeat (2) @(negedge pclk);
      chk(32'(excess_crc_alarm), 32'h1);
      rd(2, 32'd320);
      i_fr.sec();
      chk(32'(excess_crc_alarm), 32'h1);
      apb(1'b1, eec_pkg::OFF_MODE, 32'h30);
      apb(1'b1, st(3), 32'h0);
      i_fr.err(7, 2);
      rd(3, 32'h2);
      $display("frame and crc test done");
      apb(1'b1, eec_pkg::OFF_MODE, 32'h0);
      i_fr.sec();
      i_fr.sec();
      for (int k = 0; k < 8; k++) apb(1'b1, st(k), 32'h0);
      // One error is not bursty; eight framing errors are severe.
      foreach (nerr[k]) begin
         i_fr.err(0, nerr[k]);
         i_fr.sec();
         rd(4, 32'(k + 1));
         rd(5, 32'(k > 0));
         rd(6, 32'(k > 1));
      end
      for (int k = 0; k < 8; k++) apb(1'b1, st(k), 32'h0);
      repeat (10) begin
         i_fr.err(0, 8);
         i_fr.sec();
      end
      chk(32'(unavailable_alarm), 32'h1);
      rd(6, 32'h8);
      rd(7, 32'h2);
      repeat (9) i_fr.sec();
      chk(32'(unavailable_alarm), 32'h1);
      i_fr.sec();
      chk(32'(unavailable_alarm), 32'h0);
      rd(7, 32'd11);
      apb(1'b1, eec_pkg::OFF_THR_C, 32'h1);
      apb(1'b1, eec_pkg::OFF_THR_B, 32'h3);
      i_fr.err(0, 3);
      i_fr.sec();
      rd(6, 32'h9);
      $display("second test done");
      summarize();
   end
endmodule
`default_nettype wire
